// ==== src/fpe_cfg.svh ====
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH

// Register indices; byte address is four times the index
`define FPE_IDX_CTRL   16'hf8c0
`define FPE_IDX_STAT   16'hf8c2
`define FPE_IDX_ISTAT  16'hf8e0
`define FPE_IDX_IMASK  16'hf8e1

// Control bit positions
`define FPE_CTRL_PIRQ  4
`define FPE_CTRL_PROG  5
`define FPE_CTRL_PAGE  6
`define FPE_CTRL_SECT  7
`define FPE_CTRL_VDIS  8
`define FPE_CTRL_MASK  16'h01f0
`define FPE_CTRL_RST   16'h0000

// Status bit positions
`define FPE_STAT_ERASE 0
`define FPE_STAT_PROGE 1
`define FPE_STAT_BUSY  2
`define FPE_STAT_FULL  3
`define FPE_STAT_LOSS  4
`define FPE_STAT_RST   8'h00

// Interrupt status and mask bit positions
`define FPE_IRQ_DONE   0
`define FPE_IRQ_ERR    1
`define FPE_IRQ_LOSS   2
`define FPE_IRQ_ROOM   3
`define FPE_IRQ_W      4
`define FPE_IMASK_RST  4'h0

// Double buffer depth
`define FPE_BUF_DEPTH  2

`endif

// ==== src/fpe_pkg.sv ====
package fpe_pkg;

  typedef enum logic [1:0] {
    FPE_OP_NONE = 2'h0,
    FPE_OP_PROG = 2'h1,
    FPE_OP_PAGE = 2'h2,
    FPE_OP_SECT = 2'h3
  } fpe_op_t;

  typedef enum logic [2:0] {
    FPE_ST_IDLE = 3'h1,
    FPE_ST_OP   = 3'h2,
    FPE_ST_VFY  = 3'h4
  } fpe_state_t;

endpackage

// ==== src/fpe_buf_if.sv ====
`timescale 1ns/100ps
interface fpe_buf_if #(
  parameter int W = 8
);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic         full;
  logic         empty;

  modport user  (output push_valid, push_data, pop_ready,
                 input  push_ready, pop_valid, pop_data, full, empty);
  modport store (input  push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data, full, empty);
endinterface

// ==== src/fpe_w1c.sv ====
`timescale 1ns/100ps
module fpe_w1c #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Set and clear vectors
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Sticky flags
  output logic      [W-1:0] flags
);
  initial
  begin
    if (W < 1)
      $error("fpe_w1c: W must be at least 1");
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= '0;
    else
      flags <= (flags & ~clr) | set;
  end
endmodule

// ==== src/fpe_dbuf.sv ====
`timescale 1ns/100ps
module fpe_dbuf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Buffer port
  fpe_buf_if.store  b
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("fpe_dbuf: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0]   count_r;
  logic          do_push;
  logic          do_pop;

  assign b.full       = (count_r == (PW+1)'(DEPTH));
  assign b.empty      = (count_r == '0);
  assign b.push_ready = !b.full;
  assign b.pop_valid  = !b.empty;
  assign b.pop_data   = mem[rd_ptr_r];
  assign do_push      = b.push_valid && b.push_ready;
  assign do_pop       = b.pop_valid && b.pop_ready;

  always_ff @(posedge pclk)
  begin
    if (do_push)
      mem[wr_ptr_r] <= b.push_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (do_push && !do_pop)
        count_r <= count_r + 1'b1;
      else if (do_pop && !do_push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// ==== src/fpe_ctrl.sv ====
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "fpe_cfg.svh"
module fpe_ctrl #(
  parameter int AW       = 16,
  parameter int DW       = 16,
  parameter int INFO_BIT = 15
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [17:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Core writes into the flash array
  input  wire logic          core_wr_valid,
  input  wire logic [AW-1:0] core_wr_addr,
  input  wire logic [DW-1:0] core_wr_data,
  // Other requester
  input  wire logic          host_req,
  input  wire logic [1:0]    host_op,
  input  wire logic [AW-1:0] host_addr,
  input  wire logic [DW-1:0] host_data,
  output logic               host_ack,
  output logic               host_fail,
  // Flash macro
  input  wire logic          clocks_ready,
  output logic               fm_start,
  output logic      [1:0]    fm_op,
  output logic               fm_verify,
  output logic      [AW-1:0] fm_addr,
  output logic      [DW-1:0] fm_data,
  input  wire logic          fm_done,
  input  wire logic          fm_fail,
  // Interrupts
  output logic               prog_irq_req,
  output logic               irq
);
  localparam int BW = 3 + AW + DW;

  initial
  begin
    if (AW < 2 || DW < 1 || DW > 16)
      $error("fpe_ctrl: AW must be at least 2 and DW within 1..16");
    if (INFO_BIT < 0 || INFO_BIT >= AW)
      $error("fpe_ctrl: INFO_BIT must lie inside the address");
  end

  fpe_buf_if #(.W(BW)) bq ();

  fpe_dbuf #(
    .W     (BW),
    .DEPTH (`FPE_BUF_DEPTH)
  ) u_dbuf (
    .pclk    (pclk),
    .presetn (presetn),
    .b       (bq.store)
  );

  logic [15:0]           ctrl_r;
  logic [`FPE_IRQ_W-1:0] imask_r;
  logic [31:0]           prdata_r;
  logic                  slverr_r;
  logic                  full_q_r;
  fpe_pkg::fpe_state_t   state_r;
  fpe_pkg::fpe_op_t      cur_op_r;
  logic [AW-1:0]         cur_addr_r;
  logic                  cur_vfy_r;
  logic                  cur_core_r;
  logic                  second_r;
  logic                  fail_acc_r;

  logic                  bus_wr;
  logic                  bus_setup;
  logic                  sel_ctrl;
  logic                  sel_stat;
  logic                  sel_istat;
  logic                  sel_imask;
  logic                  hit;
  fpe_pkg::fpe_op_t      core_op;
  logic                  busy;
  logic [7:0]            stat_word;
  logic [2:0]            err_flags;
  logic [2:0]            err_set;
  logic [2:0]            err_clr;
  logic [`FPE_IRQ_W-1:0] istat;
  logic [`FPE_IRQ_W-1:0] ievt;
  logic [`FPE_IRQ_W-1:0] iclr;
  logic                  take_buf;
  logic                  take_host;
  logic                  go_vfy;
  logic                  op_end;
  logic                  fin;
  logic                  again;
  logic                  err_now;
  logic                  loss_evt;
  logic                  entry_vdis;
  fpe_pkg::fpe_op_t      entry_op;
  logic [AW-1:0]         entry_addr;
  logic [DW-1:0]         entry_data;

  // APB decode, zero wait states
  assign bus_wr    = psel && penable && pwrite;
  assign bus_setup = psel && !penable;
  assign sel_ctrl  = (paddr[17:2] == `FPE_IDX_CTRL);
  assign sel_stat  = (paddr[17:2] == `FPE_IDX_STAT);
  assign sel_istat = (paddr[17:2] == `FPE_IDX_ISTAT);
  assign sel_imask = (paddr[17:2] == `FPE_IDX_IMASK);
  assign hit       = sel_ctrl || sel_stat || sel_istat || sel_imask;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && slverr_r;
  assign prdata    = prdata_r;

  // Mode decode; an ambiguous mix of bits selects nothing
  always_comb
  begin
    core_op = fpe_pkg::FPE_OP_NONE;
    if (ctrl_r[`FPE_CTRL_PROG] && !ctrl_r[`FPE_CTRL_PAGE] && !ctrl_r[`FPE_CTRL_SECT])
      core_op = fpe_pkg::FPE_OP_PROG;
    else if (ctrl_r[`FPE_CTRL_PAGE] && !ctrl_r[`FPE_CTRL_PROG]
             && !ctrl_r[`FPE_CTRL_SECT])
      core_op = fpe_pkg::FPE_OP_PAGE;
    else if (ctrl_r[`FPE_CTRL_SECT] && !ctrl_r[`FPE_CTRL_PROG]
             && !ctrl_r[`FPE_CTRL_PAGE])
      core_op = fpe_pkg::FPE_OP_SECT;
  end

  // Mode and verify choice are frozen per entry at write time
  assign bq.push_valid = core_wr_valid && (core_op != fpe_pkg::FPE_OP_NONE);
  assign bq.push_data  = {ctrl_r[`FPE_CTRL_VDIS], core_op, core_wr_addr, core_wr_data};
  assign loss_evt      = core_wr_valid && bq.full;
  assign entry_vdis    = bq.pop_data[BW-1];
  assign entry_op      = fpe_pkg::fpe_op_t'(bq.pop_data[BW-2:BW-3]);
  assign entry_addr    = bq.pop_data[AW+DW-1:DW];
  assign entry_data    = bq.pop_data[DW-1:0];

  // Core buffer has priority over the other requester
  assign take_buf     = (state_r == fpe_pkg::FPE_ST_IDLE) && clocks_ready && bq.pop_valid;
  // A pending answer blocks a second take of the same request
  assign take_host    = (state_r == fpe_pkg::FPE_ST_IDLE) && clocks_ready
                        && !bq.pop_valid && host_req && !host_ack;
  assign bq.pop_ready = take_buf;
  assign go_vfy       = (state_r == fpe_pkg::FPE_ST_OP) && fm_done && cur_vfy_r;
  assign op_end       = fm_done && (((state_r == fpe_pkg::FPE_ST_OP) && !cur_vfy_r)
                        || (state_r == fpe_pkg::FPE_ST_VFY));
  assign again        = op_end && second_r;
  assign fin          = op_end && !second_r;
  assign err_now      = fail_acc_r || fm_fail;

  assign busy = !clocks_ready || (state_r != fpe_pkg::FPE_ST_IDLE) || !bq.empty;

  // Errors only from core operations, raised as an operation ends; loss raised on a core write while full
  assign err_set[0] = fin && cur_core_r && err_now
                      && (cur_op_r != fpe_pkg::FPE_OP_PROG);
  assign err_set[1] = fin && cur_core_r && err_now
                      && (cur_op_r == fpe_pkg::FPE_OP_PROG);
  assign err_set[2] = loss_evt;
  assign err_clr[0] = bus_wr && sel_stat && pstrb[0] && pwdata[`FPE_STAT_ERASE];
  assign err_clr[1] = bus_wr && sel_stat && pstrb[0] && pwdata[`FPE_STAT_PROGE];
  assign err_clr[2] = bus_wr && sel_stat && pstrb[0] && pwdata[`FPE_STAT_LOSS];

  fpe_w1c #(.W(3)) u_err (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (err_set),
    .clr     (err_clr),
    .flags   (err_flags)
  );

  always_comb
  begin
    stat_word                  = `FPE_STAT_RST;
    stat_word[`FPE_STAT_ERASE] = err_flags[0];
    stat_word[`FPE_STAT_PROGE] = err_flags[1];
    stat_word[`FPE_STAT_BUSY]  = busy;
    stat_word[`FPE_STAT_FULL]  = bq.full;
    stat_word[`FPE_STAT_LOSS]  = err_flags[2];
  end

  // Interrupt events
  assign ievt[`FPE_IRQ_DONE] = fin && cur_core_r;
  assign ievt[`FPE_IRQ_ERR]  = err_set[0] || err_set[1];
  assign ievt[`FPE_IRQ_LOSS] = loss_evt;
  assign ievt[`FPE_IRQ_ROOM] = full_q_r && !bq.full;
  assign iclr                = (bus_wr && sel_istat && pstrb[0])
                               ? pwdata[`FPE_IRQ_W-1:0] : '0;

  fpe_w1c #(.W(`FPE_IRQ_W)) u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (ievt),
    .clr     (iclr),
    .flags   (istat)
  );

  assign irq          = |(istat & imask_r);
  assign prog_irq_req = ctrl_r[`FPE_CTRL_PIRQ] && !bq.full;

  // Control register; software keeps erase bits steady while busy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `FPE_CTRL_RST;
    else if (bus_wr && sel_ctrl)
    begin
      if (pstrb[0])
        ctrl_r[7:0] <= pwdata[7:0] & 8'(`FPE_CTRL_MASK);
      if (pstrb[1])
        ctrl_r[15:8] <= pwdata[15:8] & 8'(`FPE_CTRL_MASK >> 8);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imask_r <= `FPE_IMASK_RST;
    else if (bus_wr && sel_imask && pstrb[0])
      imask_r <= pwdata[`FPE_IRQ_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      full_q_r <= 1'b0;
    else
      full_q_r <= bq.full;
  end

  // Read data and error are captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end
    else if (bus_setup)
    begin
      slverr_r <= !hit;
      prdata_r <= 32'h0000_0000;
      if (sel_ctrl)
        prdata_r[15:0] <= ctrl_r;
      else if (sel_stat)
        prdata_r[7:0] <= stat_word;
      else if (sel_istat)
        prdata_r[`FPE_IRQ_W-1:0] <= istat;
      else if (sel_imask)
        prdata_r[`FPE_IRQ_W-1:0] <= imask_r;
    end
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= fpe_pkg::FPE_ST_IDLE;
    else
    begin
      case (state_r)
        fpe_pkg::FPE_ST_IDLE:
        begin
          if (take_buf || take_host)
            state_r <= fpe_pkg::FPE_ST_OP;
        end
        fpe_pkg::FPE_ST_OP:
        begin
          if (go_vfy)
            state_r <= fpe_pkg::FPE_ST_VFY;
          else if (fin)
            state_r <= fpe_pkg::FPE_ST_IDLE;
        end
        fpe_pkg::FPE_ST_VFY:
        begin
          if (again)
            state_r <= fpe_pkg::FPE_ST_OP;
          else if (fin)
            state_r <= fpe_pkg::FPE_ST_IDLE;
        end
        default:
          state_r <= fpe_pkg::FPE_ST_IDLE;
      endcase
    end
  end

  // Operation context
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_op_r   <= fpe_pkg::FPE_OP_NONE;
      cur_addr_r <= '0;
      cur_vfy_r  <= 1'b0;
      cur_core_r <= 1'b0;
      second_r   <= 1'b0;
      fail_acc_r <= 1'b0;
    end
    else if (take_buf)
    begin
      cur_op_r   <= entry_op;
      cur_addr_r <= entry_addr;
      cur_vfy_r  <= !entry_vdis;
      cur_core_r <= 1'b1;
      second_r   <= (entry_op == fpe_pkg::FPE_OP_SECT) && entry_addr[INFO_BIT];
      fail_acc_r <= 1'b0;
    end
    else if (take_host)
    begin
      cur_op_r   <= fpe_pkg::fpe_op_t'(host_op);
      cur_addr_r <= host_addr;
      cur_vfy_r  <= 1'b1;
      cur_core_r <= 1'b0;
      second_r   <= 1'b0;
      fail_acc_r <= 1'b0;
    end
    else
    begin
      if (go_vfy)
        fail_acc_r <= fail_acc_r || fm_fail;
      if (again)
      begin
        second_r          <= 1'b0;
        fail_acc_r        <= err_now;
        cur_addr_r[INFO_BIT] <= 1'b0;
      end
    end
  end

  // Flash macro command, one start pulse per pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fm_start  <= 1'b0;
      fm_op     <= 2'h0;
      fm_verify <= 1'b0;
      fm_addr   <= '0;
      fm_data   <= '0;
    end
    else
    begin
      fm_start <= take_buf || take_host || go_vfy || again;
      if (take_buf)
      begin
        fm_op     <= entry_op;
        fm_verify <= 1'b0;
        fm_addr   <= entry_addr;
        fm_data   <= entry_data;
      end
      else if (take_host)
      begin
        fm_op     <= host_op;
        fm_verify <= 1'b0;
        fm_addr   <= host_addr;
        fm_data   <= host_data;
      end
      else if (go_vfy)
        fm_verify <= 1'b1;
      else if (again)
      begin
        fm_verify         <= 1'b0;
        fm_addr           <= cur_addr_r;
        fm_addr[INFO_BIT] <= 1'b0;
      end
    end
  end

  // Other requester answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_ack  <= 1'b0;
      host_fail <= 1'b0;
    end
    else
    begin
      host_ack  <= fin && !cur_core_r;
      host_fail <= fin && !cur_core_r && err_now;
    end
  end
endmodule

// ==== test/fpe_ctrl_monitor.sv ====
`timescale 1ns/100ps
`include "fpe_cfg.svh"
module fpe_ctrl_monitor #(
  parameter int AW       = 16,
  parameter int INFO_BIT = 15
) (
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [17:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic          pready,
  // Requests and flash macro
  input wire logic          host_req,
  input wire logic          fm_start,
  input wire logic [1:0]    fm_op,
  input wire logic          fm_verify,
  input wire logic [AW-1:0] fm_addr,
  input wire logic          fm_done,
  // Interrupts
  input wire logic          prog_irq_req,
  input wire logic          irq
);
  logic          wr_h;
  logic [8:4]    ctrl_h;
  logic [3:0]    mask_h;
  logic          info_h;
  logic [AW-1:0] info_a;
  assign wr_h = psel && penable && pwrite && pready;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadows rely on software keeping mode bits still while busy
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_h <= '0;
      mask_h <= '0;
    end
    else if (wr_h && paddr == {`FPE_IDX_CTRL, 2'b00})
    begin
      if (pstrb[0])
        ctrl_h[7:4] <= pwdata[7:4];
      if (pstrb[1])
        ctrl_h[8] <= pwdata[8];
    end
    else if (wr_h && paddr == {`FPE_IDX_IMASK, 2'b00} && pstrb[0])
      mask_h <= pwdata[3:0];
  // Marks the main pass of an info-section erase
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      info_h <= 1'b0;
      info_a <= '0;
    end
    else if (fm_start && !fm_verify && !host_req)
    begin
      info_h <= !info_h && fm_op == fpe_pkg::FPE_OP_SECT && fm_addr[INFO_BIT];
      info_a <= fm_addr;
    end
  sequence core_main;
    fm_start && !fm_verify && !host_req && !info_h;
  endsequence
  sequence host_pass;
    (fm_start && host_req && !fm_verify) ##[1:20] (fm_done && !fm_verify);
  endsequence
  a_prog_mode_only: assert property (core_main ##0 fm_op == fpe_pkg::FPE_OP_PROG
    |-> ctrl_h[7:5] == 3'b001) else $error("program pass without program-only mode");
  a_page_mode_only: assert property (core_main ##0 fm_op == fpe_pkg::FPE_OP_PAGE
    |-> ctrl_h[7:5] == 3'b010) else $error("page erase without page-only mode");
  a_sect_mode_only: assert property (core_main ##0 fm_op == fpe_pkg::FPE_OP_SECT
    |-> ctrl_h[7:5] == 3'b100) else $error("section erase without section-only mode");
  a_verify_skip: assert property (fm_start && fm_verify && !host_req
    |-> !ctrl_h[8]) else $error("verify pass while verify disabled");
  a_verify_follows: assert property (fm_start && fm_verify |-> $past(fm_done))
    else $error("verify pass not right after a done");
  a_host_verify: assert property (host_pass |=> fm_start && fm_verify)
    else $error("host pass not verified");
  a_irq_req_gate: assert property (!ctrl_h[4] |-> !prog_irq_req)
    else $error("program request while disabled");
  a_irq_masked: assert property (mask_h == 4'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  a_info_pair: assert property (fm_start && !fm_verify && info_h
    |-> fm_op == fpe_pkg::FPE_OP_SECT && fm_addr == (info_a & ~(AW'(1) << INFO_BIT)))
    else $error("info erase without matching main section");
endmodule
bind fpe_ctrl fpe_ctrl_monitor #(.AW(AW), .INFO_BIT(INFO_BIT)) i_mon (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .host_req, .fm_start,
  .fm_op, .fm_verify, .fm_addr, .fm_done, .prog_irq_req, .irq);

// ==== test/fpe_flash_model.sv ====
`timescale 1ns/100ps
module fpe_flash_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Pass request
  input  wire logic        fm_start,
  input  wire logic [1:0]  fm_op,
  input  wire logic        fm_verify,
  input  wire logic [15:0] fm_addr,
  // Bench controls
  input  wire logic        slow,
  input  wire logic        fail_on,
  // Pass result
  output logic             fm_done,
  output logic             fm_fail
);
  int          n_pass;
  logic [3:0]  cnt_r;
  logic [15:0] lg_addr [8];
  logic [1:0]  lg_op [8];
  logic        lg_vfy [8];
  // Two pass lengths so the sequencer meets prompt and slow answers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_r   <= '0;
      fm_done <= 1'b0;
      fm_fail <= 1'b0;
      n_pass  <= 0;
    end
    else
    begin
      fm_done <= cnt_r == 4'h1;
      // Result means nothing outside done, so it keeps changing there
      fm_fail <= (cnt_r == 4'h1) ? fail_on : ~fm_fail;
      if (fm_start)
      begin
        cnt_r           <= slow ? 4'h8 : 4'h2;
        lg_addr[n_pass % 8] <= fm_addr;
        lg_op[n_pass % 8]   <= fm_op;
        lg_vfy[n_pass % 8]  <= fm_verify;
        n_pass          <= n_pass + 1;
      end
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`include "fpe_cfg.svh"
module tb_top;
  localparam logic [17:0] A_CTRL = {`FPE_IDX_CTRL, 2'b00};
  localparam logic [17:0] A_STAT = {`FPE_IDX_STAT, 2'b00};
  localparam logic [17:0] A_IST  = {`FPE_IDX_ISTAT, 2'b00};
  localparam logic [17:0] A_IMSK = {`FPE_IDX_IMASK, 2'b00};
  localparam logic [17:0] A_NONE = {16'hf8c1, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        core_wr_valid, host_req, host_ack, host_fail, clocks_ready;
  logic [15:0] core_wr_addr, core_wr_data, host_addr, host_data, fm_addr, fm_data;
  logic [1:0]  host_op, fm_op;
  logic        fm_start, fm_verify, fm_done, fm_fail, prog_irq_req, irq, slow, fail_on;
  int          bad_count, n_tests, p0, k;
  logic [17:0] regs [4] = '{A_CTRL, A_STAT, A_IST, A_IMSK};
  logic [31:0] bad_modes [5] = '{32'h60, 32'ha0, 32'hc0, 32'he0, 32'h0};
  fpe_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .core_wr_valid, .core_wr_addr, .core_wr_data, .host_req,
    .host_op, .host_addr, .host_data, .host_ack, .host_fail, .clocks_ready, .fm_start,
    .fm_op, .fm_verify, .fm_addr, .fm_data, .fm_done, .fm_fail, .prog_irq_req, .irq);
  fpe_flash_model i_fm (.pclk, .presetn, .fm_start, .fm_op, .fm_verify, .fm_addr, .slow,
    .fail_on, .fm_done, .fm_fail);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Always leaves one idle cycle, so drivers never change twice in a step
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic core_wr(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++)
    begin
      core_wr_valid <= 1'b1;
      core_wr_addr  <= a + 16'(i);
      core_wr_data  <= 16'h5a00 ^ a;
      @(posedge pclk);
    end
    core_wr_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // Only the watchdog ends a hang here
  task automatic wait_idle;
    rd = 32'h4;
    while (rd[2] !== 1'b0)
      apb(1'b0, A_STAT, 32'h0);
  endtask
  task automatic run_op(input logic [31:0] c, input logic [15:0] a, input logic f,
                        input int np, input logic [1:0] op, input logic [31:0] st);
    fail_on <= f;
    apb(1'b1, A_CTRL, c);
    p0 = i_fm.n_pass;
    core_wr(a, 1);
    wait_idle();
    chk(32'(i_fm.n_pass - p0), 32'(np), "pass count");
    if (np > 0)
    begin
      chk(i_fm.lg_addr[p0 % 8], a, "pass address");
      chk(i_fm.lg_op[p0 % 8], op, "pass operation");
      chk(fm_data, 16'h5a00 ^ a, "pass data");
    end
    chk(rd & 32'h13, st, "error flags");
    apb(1'b1, A_STAT, 32'h13);
    apb(1'b1, A_IST, 32'hf);
  endtask
  initial
  begin
    {psel, penable, pwrite, core_wr_valid, host_req, slow, fail_on, presetn} = '0;
    {paddr, pwdata, core_wr_addr, core_wr_data, host_op, host_addr, host_data} = '0;
    pstrb        = 4'hf;
    clocks_ready = 1'b1;
    bad_count    = 0;
    n_tests      = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    apb(1'b1, A_CTRL, 32'hffffffff);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h1f0, "control bits");
    apb(1'b0, A_NONE, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    clocks_ready <= 1'b0;
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h4, "busy without clocks");
    clocks_ready <= 1'b1;
    $display("test reset done");
    run_op(32'h20, 16'h0123, 1'b0, 2, 2'h1, 32'h0);
    run_op(32'h20, 16'h0124, 1'b1, 2, 2'h1, 32'h2);
    run_op(32'h140, 16'h0200, 1'b1, 1, 2'h2, 32'h1);
    run_op(32'h80, 16'h8010, 1'b0, 4, 2'h3, 32'h0);
    chk(i_fm.lg_addr[(p0 + 2) % 8], 16'h0010, "matching main section");
    chk(i_fm.lg_vfy[(p0 + 1) % 8], 1'b1, "section verified");
    run_op(32'h80, 16'h0020, 1'b0, 2, 2'h3, 32'h0);
    foreach (bad_modes[i])
      run_op(bad_modes[i], 16'h0300, 1'b0, 0, 2'h0, 32'h0);
    $display("test operations done");
    apb(1'b1, A_IMSK, 32'h4);
    apb(1'b1, A_CTRL, 32'h30);
    slow <= 1'b1;
    core_wr(16'h0400, 4);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[4:2], 3'b111, "full, busy and overrun");
    @(negedge pclk);
    chk(prog_irq_req, 1'b0, "request while full");
    chk(irq, 1'b1, "overrun interrupt");
    @(posedge pclk);
    apb(1'b1, A_IMSK, 32'h0);
    @(negedge pclk);
    chk(irq, 1'b0, "masked interrupt");
    @(posedge pclk);
    wait_idle();
    chk(rd[4:3], 2'b10, "room after drain");
    @(negedge pclk);
    chk(prog_irq_req, 1'b1, "request with room");
    @(posedge pclk);
    apb(1'b1, A_STAT, 32'h0);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[4], 1'b1, "zero write kept flag");
    apb(1'b1, A_STAT, 32'h10);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[4], 1'b0, "one write cleared flag");
    apb(1'b1, A_IMSK, 32'h4);
    apb(1'b1, A_IST, 32'h4);
    apb(1'b1, A_CTRL, 32'h140);
    @(negedge pclk);
    chk(irq, 1'b0, "cleared interrupt");
    chk(prog_irq_req, 1'b0, "request disabled");
    @(posedge pclk);
    slow <= 1'b0;
    $display("test overrun done");
    fail_on   <= 1'b1;
    p0 = i_fm.n_pass;
    host_req  <= 1'b1;
    host_op   <= 2'h1;
    host_addr <= 16'h0500;
    host_data <= 16'h1234;
    k = 0;
    do
    begin
      @(negedge pclk);
      k++;
    end
    while (host_ack !== 1'b1 && k < 200);
    chk(host_fail, 1'b1, "host failure");
    chk(32'(i_fm.n_pass - p0), 32'h2, "host verified");
    chk(i_fm.lg_op[p0 % 8], 2'h1, "host operation");
    chk(fm_data, 16'h1234, "host data");
    @(posedge pclk);
    host_req <= 1'b0;
    wait_idle();
    chk(rd & 32'h13, 32'h0, "host leaves flags");
    $display("test host done");
    give_verdict();
  end
  // A few hundred cycles are needed; the 30000-cycle limit leaves wide margin
  initial
  begin
    #(50 * 30000);
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
